// file: verilog/printer_check_pkg.sv
// Shared constants, types and layouts for the printer check and sense block
package printer_check_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int BYTE_W = 8;
    localparam int SRC_W = 4;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ****************************************
    // Sense byte, bit 0 is the most significant
    // ****************************************
    localparam int SNS_CMD_REJECT = 7;
    localparam int SNS_INTV_REQ = 6;
    localparam int SNS_BUS_OUT = 5;
    localparam int SNS_EQUIP = 4;
    localparam int SNS_DATA = 3;
    localparam int SNS_UNUSED5 = 2;
    localparam int SNS_UNUSED6 = 1;
    localparam int SNS_CHAN9 = 0;

    // ****************************************
    // Status byte and stored status word
    // ****************************************
    localparam int STAT_UNIT_CHECK = 1;
    localparam int CSW_UNIT_CHECK_BIT = 38;
    localparam logic [7:0] CSW_UC_BYTE_ADDR = 8'h44;

    // ****************************************
    // External source-select decodes
    // ****************************************
    localparam logic [3:0] SRC_ADDR_RB = 4'hA;
    localparam logic [3:0] SRC_DATA_RB = 4'hB;
    localparam logic [3:0] SRC_SENSE = 4'hE;

    // ****************************************
    // Sense/status facility layout
    // ****************************************
    localparam int PRS_UNIT_CHECK = 7;
    localparam int PRS_READY = 6;
    localparam int PRS_CHAN9 = 5;
    localparam int PRS_CHAN12 = 4;
    localparam int PRS_INIT_READY = 3;
    localparam int PRS_HAMMER = 2;
    localparam int PRS_PARITY = 1;
    localparam int PRS_PRINT_REQ = 0;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_NOT_READY = 3'h1,
        ST_READY = 3'h2,
        ST_ONE_LINE = 3'h4
    } ready_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic single_cycle;
        logic check_reset;
        logic carriage_stop;
        logic carriage_space;
        logic restore;
    } keys_t;

    typedef struct packed {
        logic space;
        logic skip;
        logic chan1;
        logic chan9;
        logic chan12;
    } carriage_t;

    typedef struct packed {
        logic interlock_open;
        logic forms_trouble;
        logic sync_check;
        logic coil_hazard;
        logic equip_fault;
        logic hammer_check;
        logic parity_check;
    } faults_t;

endpackage : printer_check_pkg

// file: verilog/sticky_flags.sv
// Bank of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/100ps
module sticky_flags #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Flag control
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] q_o
);
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            q_o <= '0;
        end else begin
            q_o <= set_i | (q_o & ~clr_i);
        end
    end
endmodule : sticky_flags

// file: verilog/rise_detect.sv
// Rising-edge pulses for a group of synchronous level inputs
`timescale 1ns/100ps
module rise_detect #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Levels in, pulses out
    input wire logic [W-1:0] level_i,
    output logic [W-1:0] rise_o
);
    logic [W-1:0] prev_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            prev_q <= '0;
        end else begin
            prev_q <= level_i;
        end
    end

    assign rise_o = level_i & ~prev_q;
endmodule : rise_detect

// file: verilog/printer_check_sense.sv
// Printer attachment check, sense, status and diagnostic read-back logic
//
// Operation
// - End of forms gives unit check at the next initial selection.
// - After end-of-forms unit check, sense returns intervention required.
// - End of forms drops ready and lights the end-of-forms lamp.
// - One start press readies for the rest; single-cycle prints one line.
// - Channel-1 hole in space or skip ends operation, sets end of forms.
// - After channel-1 hole printing is suppressed until ready again.
// - Forms check blocks the start key until check reset.
// - Unit check shows in word bit 38, byte at 44 bit 6.
// - Unaccepted command sets command reject and unit check.
// - Listed stop causes drop ready and set intervention required.
// - Coil-protect check drops ready, sets print check, cuts coil supply.
// - Sense bits 2, 5 and 6 always read zero.
// - Resettable control malfunction sets equipment check.
// - Unmatched table character sets data check, suppresses that position.
// - Channel 9 seen during space sets sense bit 7.
// - Use meter conditions on ready write, runs with customer meter.
// - Power-on reset clears checks and makes printer not ready.
// - System reset likewise but a ready printer stays ready.
// - Data read-back goes out under source decode B.
// - Address read-back goes out under source decode A.
// - Sense/status facility answers decode E for moves and branches.
`timescale 1ns/100ps
module printer_check_sense (
    // Clock and resets
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic sys_reset_i,
    // Operator keys and printer mechanism
    input wire printer_check_pkg::keys_t keys_i,
    input wire printer_check_pkg::carriage_t carriage_i,
    input wire printer_check_pkg::faults_t faults_i,
    input wire logic eof_cond_i,
    input wire logic line_done_i,
    // Channel side
    input wire logic cmd_strobe_i,
    input wire logic cmd_invalid_i,
    input wire logic write_op_i,
    input wire logic init_sel_i,
    input wire logic sense_op_i,
    // Character compare
    input wire logic table_option_i,
    input wire logic char_strobe_i,
    input wire logic char_match_i,
    // Line buffer and external source select
    input wire logic [7:0] lb_data_i,
    input wire logic [7:0] lb_addr_i,
    input wire logic diag_capture_i,
    input wire logic [3:0] src_sel_i,
    input wire logic src_move_i,
    input wire logic src_branch_i,
    input wire logic [7:0] branch_mask_i,
    // Customer meter
    input wire logic cpu_meter_run_i,
    // Status and sense out
    output logic [7:0] status_o,
    output logic [7:0] csw_byte_o,
    output logic [7:0] sense_o,
    output logic [7:0] src_data_o,
    output logic branch_taken_o,
    // Printer indications and controls
    output logic ready_o,
    output logic eof_light_o,
    output logic forms_check_o,
    output logic print_check_o,
    output logic coil_supply_o,
    output logic print_enable_o,
    output logic position_suppress_o,
    output logic terminate_o,
    output logic use_meter_o
);

    // ****************************************
    // Key edges
    // ****************************************
    printer_check_pkg::keys_t key_rise;
    logic eof_rise;

    rise_detect #(.W($bits(printer_check_pkg::keys_t) + 1)) u_keys (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .level_i({keys_i, eof_cond_i}),
        .rise_o({key_rise, eof_rise})
    );

    // ****************************************
    // Check latches: forms, sync, coil
    // ****************************************
    logic [2:0] chk_set;
    logic [2:0] chk_clr;
    logic [2:0] chk_q;
    logic forms_q;
    logic sync_q;
    logic coil_q;

    always_comb begin
        chk_set[2] = faults_i.forms_trouble | keys_i.carriage_stop;
        chk_set[1] = faults_i.sync_check;
        chk_set[0] = faults_i.coil_hazard;
        // System reset clears checks, so it must also mask new sets
        if (sys_reset_i) begin
            chk_set = 3'h0;
        end
        chk_clr = {3{key_rise.check_reset | sys_reset_i}};
    end

    sticky_flags #(.W(3)) u_checks (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .set_i(chk_set),
        .clr_i(chk_clr),
        .q_o(chk_q)
    );

    assign forms_q = chk_q[2];
    assign sync_q = chk_q[1];
    assign coil_q = chk_q[0];

    // ****************************************
    // Ready state machine
    // ****************************************
    printer_check_pkg::ready_state_t state_q;
    printer_check_pkg::ready_state_t state_d;
    logic chan1_hit;
    logic eof_event;
    logic blocked;
    logic hard_stop;
    logic sc_stop;
    logic intv_set;
    logic eof_q;
    logic suppress_q;
    logic suppress_d;

    assign chan1_hit = carriage_i.chan1 & (carriage_i.space | carriage_i.skip);
    assign eof_event = (eof_rise | chan1_hit) & ~sys_reset_i;
    // Any latched or arriving check keeps the start key dead
    assign blocked = (|chk_q) | (|chk_set) | faults_i.interlock_open;
    assign hard_stop = keys_i.stop | faults_i.interlock_open | (|chk_set)
        | eof_event;
    assign sc_stop = key_rise.single_cycle & (state_q == printer_check_pkg::ST_READY);

    always_comb begin
        state_d = state_q;
        case (state_q)
            printer_check_pkg::ST_NOT_READY: begin
                if (key_rise.start & ~blocked & ~keys_i.stop) begin
                    state_d = printer_check_pkg::ST_READY;
                end else if (key_rise.single_cycle & ~blocked & ~keys_i.stop) begin
                    state_d = printer_check_pkg::ST_ONE_LINE;
                end
            end
            printer_check_pkg::ST_READY: begin
                if (hard_stop | sc_stop) begin
                    state_d = printer_check_pkg::ST_NOT_READY;
                end
            end
            printer_check_pkg::ST_ONE_LINE: begin
                if (hard_stop | line_done_i) begin
                    state_d = printer_check_pkg::ST_NOT_READY;
                end
            end
            default: begin
                state_d = printer_check_pkg::ST_NOT_READY;
            end
        endcase
        // Outcome of a running operation is not defined here
        if (sys_reset_i) begin
            state_d = (state_q == printer_check_pkg::ST_READY)
                ? printer_check_pkg::ST_READY
                : printer_check_pkg::ST_NOT_READY;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= printer_check_pkg::ST_NOT_READY;
            ready_o <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_o <= (state_d == printer_check_pkg::ST_READY);
        end
    end

    assign intv_set = eof_event
        | ((state_q != printer_check_pkg::ST_NOT_READY) & (hard_stop | sc_stop));

    // ****************************************
    // End of forms and print suppression
    // ****************************************
    always_comb begin
        suppress_d = suppress_q;
        if (state_q == printer_check_pkg::ST_NOT_READY
            && state_d != printer_check_pkg::ST_NOT_READY) begin
            suppress_d = 1'b0;
        end
        if (chan1_hit) begin
            suppress_d = 1'b1;
        end
        if (sys_reset_i) begin
            suppress_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            eof_q <= 1'b0;
            suppress_q <= 1'b0;
            eof_light_o <= 1'b0;
            terminate_o <= 1'b0;
            print_enable_o <= 1'b0;
        end else begin
            if (eof_event) begin
                eof_q <= 1'b1;
            end else if (sys_reset_i || (state_q == printer_check_pkg::ST_NOT_READY
                         && state_d != printer_check_pkg::ST_NOT_READY)) begin
                eof_q <= 1'b0;
            end
            eof_light_o <= eof_event | (eof_q & ~sys_reset_i
                & ~(state_d != printer_check_pkg::ST_NOT_READY
                & state_q == printer_check_pkg::ST_NOT_READY));
            suppress_q <= suppress_d;
            terminate_o <= chan1_hit;
            print_enable_o <= (state_d != printer_check_pkg::ST_NOT_READY)
                & ~suppress_d;
        end
    end

    // ****************************************
    // Coil protect and forms indications
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            forms_check_o <= 1'b0;
            print_check_o <= 1'b0;
            coil_supply_o <= 1'b0;
        end else begin
            forms_check_o <= chk_set[2] | (forms_q & ~chk_clr[2]);
            print_check_o <= chk_set[0] | (coil_q & ~chk_clr[0]);
            coil_supply_o <= ~(chk_set[0] | (coil_q & ~chk_clr[0]));
        end
    end

    // ****************************************
    // Sense bits: reject, intervention, equipment, data, channel 9
    // ****************************************
    logic data_mismatch;
    logic [4:0] sns_set;
    logic [4:0] sns_q;

    assign data_mismatch = table_option_i & char_strobe_i & ~char_match_i;

    always_comb begin
        sns_set[4] = cmd_strobe_i & cmd_invalid_i;
        sns_set[3] = intv_set;
        sns_set[2] = faults_i.equip_fault;
        sns_set[1] = data_mismatch;
        sns_set[0] = carriage_i.space & carriage_i.chan9;
        if (sys_reset_i) begin
            sns_set = 5'h00;
        end
    end

    // Sense is consumed by the sense operation that reports it
    sticky_flags #(.W(5)) u_sense (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .set_i(sns_set),
        .clr_i({5{sense_op_i | sys_reset_i}}),
        .q_o(sns_q)
    );

    logic [7:0] sense_now;

    always_comb begin
        sense_now = printer_check_pkg::BYTE_ZERO;
        sense_now[printer_check_pkg::SNS_CMD_REJECT] = sns_q[4];
        sense_now[printer_check_pkg::SNS_INTV_REQ] = sns_q[3];
        sense_now[printer_check_pkg::SNS_EQUIP] = sns_q[2];
        sense_now[printer_check_pkg::SNS_DATA] = sns_q[1];
        sense_now[printer_check_pkg::SNS_CHAN9] = sns_q[0];
    end

    // ****************************************
    // Unit check and status presentation
    // ****************************************
    logic uc_q;
    logic uc_set;

    assign uc_set = (eof_event | (|sns_set)) & ~sys_reset_i;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            uc_q <= 1'b0;
            status_o <= printer_check_pkg::BYTE_ZERO;
            csw_byte_o <= printer_check_pkg::BYTE_ZERO;
            sense_o <= printer_check_pkg::BYTE_ZERO;
            position_suppress_o <= 1'b0;
        end else begin
            uc_q <= uc_set | (uc_q & ~init_sel_i & ~sys_reset_i);
            if (init_sel_i) begin
                status_o <= printer_check_pkg::BYTE_ZERO;
                status_o[printer_check_pkg::STAT_UNIT_CHECK] <= uc_q;
                csw_byte_o <= printer_check_pkg::BYTE_ZERO;
                csw_byte_o[printer_check_pkg::STAT_UNIT_CHECK] <= uc_q;
            end
            if (sense_op_i) begin
                sense_o <= sense_now;
            end
            position_suppress_o <= data_mismatch;
        end
    end

    // ****************************************
    // Use meter
    // ****************************************
    logic meter_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meter_q <= 1'b0;
            use_meter_o <= 1'b0;
        end else begin
            if (write_op_i && state_q == printer_check_pkg::ST_READY) begin
                meter_q <= 1'b1;
            end else if (keys_i.carriage_space || keys_i.restore) begin
                meter_q <= 1'b0;
            end
            use_meter_o <= meter_q & cpu_meter_run_i;
        end
    end

    // ****************************************
    // Diagnostic read-back and sense/status facility
    // ****************************************
    logic [7:0] data_rb_q;
    logic [7:0] addr_rb_q;
    logic init_ready_q;
    logic print_req_q;
    logic chan12_q;
    logic [7:0] printer_sense_status_facility;
    logic prs_read;
    logic became_ready;

    assign became_ready = (state_q == printer_check_pkg::ST_NOT_READY)
        & (state_d != printer_check_pkg::ST_NOT_READY);
    assign prs_read = (src_move_i | src_branch_i)
        & (src_sel_i == printer_check_pkg::SRC_SENSE);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            data_rb_q <= printer_check_pkg::BYTE_ZERO;
            addr_rb_q <= printer_check_pkg::BYTE_ZERO;
            init_ready_q <= 1'b0;
            print_req_q <= 1'b0;
            chan12_q <= 1'b0;
        end else begin
            if (diag_capture_i) begin
                data_rb_q <= lb_data_i;
                addr_rb_q <= lb_addr_i;
            end
            // Reading the facility consumes its init-ready, print-request and channel-12 bits
            init_ready_q <= became_ready | (init_ready_q & ~prs_read);
            print_req_q <= became_ready | line_done_i | (print_req_q & ~prs_read);
            chan12_q <= (carriage_i.space & carriage_i.chan12) | (chan12_q & ~prs_read);
        end
    end

    always_comb begin
        printer_sense_status_facility = printer_check_pkg::BYTE_ZERO;
        printer_sense_status_facility[printer_check_pkg::PRS_UNIT_CHECK] = uc_q;
        printer_sense_status_facility[printer_check_pkg::PRS_READY] = ready_o;
        printer_sense_status_facility[printer_check_pkg::PRS_CHAN9] = sns_q[0];
        printer_sense_status_facility[printer_check_pkg::PRS_CHAN12] = chan12_q;
        printer_sense_status_facility[printer_check_pkg::PRS_INIT_READY] = init_ready_q;
        printer_sense_status_facility[printer_check_pkg::PRS_HAMMER] = faults_i.hammer_check;
        printer_sense_status_facility[printer_check_pkg::PRS_PARITY] = faults_i.parity_check;
        printer_sense_status_facility[printer_check_pkg::PRS_PRINT_REQ] = print_req_q;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            src_data_o <= printer_check_pkg::BYTE_ZERO;
            branch_taken_o <= 1'b0;
        end else begin
            if (src_move_i) begin
                case (src_sel_i)
                    printer_check_pkg::SRC_DATA_RB: src_data_o <= data_rb_q;
                    printer_check_pkg::SRC_ADDR_RB: src_data_o <= addr_rb_q;
                    printer_check_pkg::SRC_SENSE: src_data_o <= printer_sense_status_facility;
                    default: src_data_o <= printer_check_pkg::BYTE_ZERO;
                endcase
            end
            branch_taken_o <= src_branch_i
                & (src_sel_i == printer_check_pkg::SRC_SENSE)
                & (|(printer_sense_status_facility & branch_mask_i));
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_eof_drops_ready: assert property (eof_event |=> !ready_o && eof_light_o)
        else $error("end of forms left printer ready");
    a_eof_unit_check: assert property (eof_event ##1 init_sel_i[*1] |=>
        status_o[printer_check_pkg::STAT_UNIT_CHECK])
        else $error("unit check missing after end of forms");
    a_eof_intv_sense: assert property (eof_event ##1 (sense_op_i && !sys_reset_i) |=>
        sense_o[printer_check_pkg::SNS_INTV_REQ])
        else $error("intervention not sensed after end of forms");
    a_chan1_suppress: assert property (chan1_hit |=> !print_enable_o && terminate_o)
        else $error("printing not suppressed after channel 1");
    a_forms_blocks: assert property (forms_q && !ready_o |=> !ready_o)
        else $error("start key took effect under forms check");
    a_csw_mirror: assert property (init_sel_i |=>
        csw_byte_o == status_o)
        else $error("status word byte differs from status");
    a_cmd_reject: assert property (cmd_strobe_i && cmd_invalid_i && !sys_reset_i
        ##1 sense_op_i |=> sense_o[printer_check_pkg::SNS_CMD_REJECT])
        else $error("command reject not sensed");
    a_coil_cutoff: assert property (chk_set[0] |=>
        !coil_supply_o && print_check_o && !ready_o)
        else $error("coil check did not cut supply");
    a_unused_zero: assert property (sense_o[printer_check_pkg::SNS_BUS_OUT] == 1'b0
        && sense_o[printer_check_pkg::SNS_UNUSED5] == 1'b0
        && sense_o[printer_check_pkg::SNS_UNUSED6] == 1'b0)
        else $error("unused sense bit reported");
    a_meter_gate: assert property (use_meter_o |-> $past(meter_q))
        else $error("meter ran while not conditioned");
    a_sysrst_ready: assert property (sys_reset_i && ready_o && state_q ==
        printer_check_pkg::ST_READY |=> ready_o)
        else $error("system reset dropped a ready printer");
    a_src_move_e: assert property (src_move_i && src_sel_i ==
        printer_check_pkg::SRC_SENSE |=> src_data_o == $past(printer_sense_status_facility))
        else $error("sense facility not delivered on decode E");

endmodule : printer_check_sense

// file: test/printer_mech.sv
// Behavioural printer mechanism: operator keys, carriage tape, faults
`timescale 1ns/100ps
module printer_mech (
    // Action code from the bench
    input wire logic [3:0] act_i,
    // Levels toward the attachment
    output printer_check_pkg::keys_t keys_o,
    output printer_check_pkg::carriage_t carr_o,
    output printer_check_pkg::faults_t flt_o,
    output logic eof_o
);
    // Pure levels: the bench steps the action just after an edge
    always_comb begin
        keys_o = '0;
        carr_o = '0;
        flt_o = '0;
        keys_o.start = (act_i == 4'h1);
        keys_o.stop = (act_i == 4'h2);
        keys_o.single_cycle = (act_i == 4'h6);
        keys_o.check_reset = (act_i == 4'h3);
        keys_o.carriage_stop = (act_i == 4'h4);
        keys_o.carriage_space = (act_i == 4'hB);
        flt_o.coil_hazard = (act_i == 4'h7);
        flt_o.equip_fault = (act_i == 4'h9);
        // Holes only count while the carriage moves
        carr_o.space = (act_i == 4'h8) || (act_i == 4'hA);
        carr_o.chan9 = (act_i == 4'h8);
        carr_o.chan1 = (act_i == 4'hA);
    end
    assign eof_o = (act_i == 4'h5);
endmodule : printer_mech

// file: test/test_line_printer_check_and_sense.sv
// Self-checking bench for the printer check and sense block
`timescale 1ns/100ps
module test_line_printer_check_and_sense;
    typedef struct packed {logic [3:0] act; logic [4:0] exp;} row_t;
    logic clk_i = 1'b0, reset_i = 1'b1, sys_reset_i = 1'b0, cmd_strobe_i = 1'b0;
    logic cmd_invalid_i = 1'b0, write_op_i = 1'b0, init_sel_i = 1'b0, sense_op_i = 1'b0;
    logic diag_capture_i = 1'b0, src_move_i = 1'b0, src_branch_i = 1'b0;
    logic cpu_meter_run_i = 1'b0, eof, ready_o, eof_light_o, forms_check_o;
    logic print_check_o, coil_supply_o, print_enable_o, use_meter_o, branch_taken_o;
    logic table_option_i = 1'b1, char_strobe_i = 1'b0, char_match_i = 1'b0;
    logic line_done_i = 1'b0, position_suppress_o, terminate_o;
    logic [3:0] act = 4'h0, src_sel_i = 4'h0;
    logic [7:0] lb_data_i = 8'h5A, lb_addr_i = 8'hC3, branch_mask_i = 8'h40;
    logic [7:0] status_o, csw_byte_o, sense_o, src_data_o;
    printer_check_pkg::keys_t keys;
    printer_check_pkg::carriage_t carr;
    printer_check_pkg::faults_t flt;
    int err_count = 0, samples_checked = 0, cycles = 0;
    // Columns: ready, eof light, forms check, print check, coil supply
    row_t rows [13] = '{'{4'h0, 5'h01}, '{4'h1, 5'h11}, '{4'h5, 5'h09},
        '{4'h1, 5'h11}, '{4'h2, 5'h01}, '{4'h4, 5'h05}, '{4'h1, 5'h05},
        '{4'h3, 5'h01}, '{4'h1, 5'h11}, '{4'h7, 5'h02}, '{4'h3, 5'h01},
        '{4'h1, 5'h11}, '{4'hA, 5'h09}};
    always #10 clk_i = ~clk_i;
    printer_mech i_mech (.act_i(act), .keys_o(keys), .carr_o(carr), .flt_o(flt), .eof_o(eof));
    printer_check_sense i_dut (.clk_i, .reset_i, .sys_reset_i, .keys_i(keys),
        .carriage_i(carr), .faults_i(flt), .eof_cond_i(eof), .line_done_i,
        .cmd_strobe_i, .cmd_invalid_i, .write_op_i, .init_sel_i, .sense_op_i,
        .table_option_i, .char_strobe_i, .char_match_i, .lb_data_i,
        .lb_addr_i, .diag_capture_i, .src_sel_i, .src_move_i, .src_branch_i,
        .branch_mask_i, .cpu_meter_run_i, .status_o, .csw_byte_o, .sense_o,
        .src_data_o, .branch_taken_o, .ready_o, .eof_light_o, .forms_check_o,
        .print_check_o, .coil_supply_o, .print_enable_o, .position_suppress_o,
        .terminate_o, .use_meter_o);
    // ****************************************
    // Helpers
    // ****************************************
    task cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task mv(input logic [3:0] s);
        src_sel_i = s;
        src_move_i = 1'b1;
        cyc(1);
        src_move_i = 1'b0;
        cyc(2);
    endtask : mv
    // Levels held two cycles so every edge detector sees them
    task step(input logic [3:0] a, input logic [7:0] m);
        act = a;
        cyc(2);
        act = 4'h0;
        cyc(1);
        sense_op_i = 1'b1;
        cyc(1);
        sense_op_i = 1'b0;
        cyc(2);
        chk(sense_o & m, m);
    endtask : step
    task results;
        $display("err_count=%0d samples_checked=%0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            err_count++;
            results();
        end
    end
    initial begin
        cyc(2);
        reset_i = 1'b0;
        cyc(1);
        foreach (rows[i]) begin
            act = rows[i].act;
            cyc(2);
            act = 4'h0;
            cyc(3);
            chk({3'h0, ready_o, eof_light_o, forms_check_o, print_check_o, coil_supply_o},
                {3'h0, rows[i].exp});
        end
        init_sel_i = 1'b1;
        cyc(1);
        init_sel_i = 1'b0;
        cyc(2);
        chk(status_o, 8'h02);
        chk({7'h0, csw_byte_o[1]}, 8'h01);
        chk({7'h0, print_enable_o}, 8'h00);
        step(4'h0, 8'h40);
        chk(sense_o & 8'h26, 8'h00);
        cmd_invalid_i = 1'b1;
        cmd_strobe_i = 1'b1;
        cyc(1);
        cmd_strobe_i = 1'b0;
        step(4'h0, 8'h80);
        step(4'h9, 8'h10);
        step(4'h8, 8'h01);
        char_strobe_i = 1'b1;
        cyc(1);
        char_strobe_i = 1'b0;
        chk({7'h0, position_suppress_o}, 8'h01);
        step(4'h0, 8'h08);
        act = 4'hA;
        cyc(1);
        chk({6'h0, terminate_o, print_enable_o}, 8'h02);
        act = 4'h0;
        cyc(1);
        diag_capture_i = 1'b1;
        cyc(1);
        diag_capture_i = 1'b0;
        mv(4'hA);
        chk(src_data_o, 8'hC3);
        mv(4'hB);
        chk(src_data_o, 8'h5A);
        act = 4'h1;
        cyc(2);
        act = 4'h0;
        cyc(3);
        // Reset only while no printer operation runs
        sys_reset_i = 1'b1;
        cyc(1);
        sys_reset_i = 1'b0;
        cyc(2);
        chk({7'h0, ready_o}, 8'h01);
        mv(4'hE);
        chk({7'h0, src_data_o[6]}, 8'h01);
        src_branch_i = 1'b1;
        cyc(1);
        src_branch_i = 1'b0;
        chk({7'h0, branch_taken_o}, 8'h01);
        cpu_meter_run_i = 1'b1;
        write_op_i = 1'b1;
        cyc(1);
        write_op_i = 1'b0;
        cyc(2);
        chk({7'h0, use_meter_o}, 8'h01);
        act = 4'hB;
        cyc(2);
        act = 4'h0;
        cyc(2);
        chk({7'h0, use_meter_o}, 8'h00);
        step(4'h6, 8'h40);
        chk({7'h0, ready_o}, 8'h00);
        act = 4'h6;
        cyc(2);
        act = 4'h0;
        chk({6'h0, ready_o, print_enable_o}, 8'h01);
        line_done_i = 1'b1;
        cyc(1);
        line_done_i = 1'b0;
        cyc(1);
        chk({7'h0, print_enable_o}, 8'h00);
        results();
    end
endmodule : test_line_printer_check_and_sense
